// *** verilog/modbus_pkg.sv ***
package modbus_pkg;
  // slave addresses and function codes
  localparam logic [7:0] BCAST_ADDR = 8'h00;
  localparam logic [7:0] FN_RD_HOLD = 8'h03;
  localparam logic [7:0] FN_RD_INPUT = 8'h04;
  localparam logic [7:0] FN_WR_COIL = 8'h05;
  localparam logic [7:0] FN_WR_REG = 8'h06;
  localparam logic [7:0] FN_RD_STATUS = 8'h07;
  // exception answers
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FN = 8'h01;
  localparam logic [7:0] EXC_MEMORY = 8'h02;
  localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
  localparam logic [7:0] EXC_FLAG = 8'h80;
  // downstream primitives and transfer type codes
  localparam logic [7:0] PRIM_READ = 8'h20;
  localparam logic [7:0] PRIM_WRITE = 8'h30;
  localparam logic [7:0] TT_VARIABLE = 8'h01;
  localparam logic [7:0] TT_OUT_COIL = 8'h04;
  localparam logic [7:0] TT_INT_COIL = 8'h05;
  localparam logic [7:0] TT_OUT_PACKED = 8'h07;
  localparam logic [7:0] TT_INT_PACKED = 8'h08;
  localparam logic [7:0] TT_WORD_INPUT = 8'h09;
  // coil codes
  localparam logic [15:0] CODE_ON = 16'hff00;
  localparam logic [15:0] CODE_OFF = 16'h0000;
  localparam logic [15:0] CODE_FORCE_ON = 16'h1100;
  localparam logic [15:0] CODE_FORCE_OFF = 16'h2200;
  localparam logic [15:0] CODE_UNFORCE = 16'h3300;
  // quantities
  localparam logic [15:0] MAX_REGS = 16'h007d;
  localparam logic [15:0] STATUS_START = 16'h0001;
  localparam logic [15:0] STATUS_COUNT = 16'h0008;
  // reply header lengths in bytes
  localparam logic [2:0] LEN_EXC = 3'h3;
  localparam logic [2:0] LEN_ECHO = 3'h6;
  localparam logic [2:0] LEN_DATA = 3'h3;
  localparam logic [2:0] LEN_STATUS = 3'h2;
  // reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;

  typedef enum logic [2:0] {
    COIL_OFF = 3'h0, COIL_ON = 3'h1, COIL_FORCE_ON = 3'h2, COIL_FORCE_OFF = 3'h3, COIL_UNFORCE = 3'h4
  } coil_action_type;

  typedef enum logic [2:0] {
    REPLY_NONE = 3'h0, REPLY_EXC = 3'h1, REPLY_ECHO = 3'h2, REPLY_DATA = 3'h3, REPLY_STATUS = 3'h4
  } reply_type;

  // gray along idle-issue-wait-send-load-hi-lo
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0, ST_ISSUE = 3'h1, ST_WAIT = 3'h3, ST_SEND = 3'h2,
    ST_LOAD = 3'h6, ST_DATA_HI = 3'h7, ST_DATA_LO = 3'h5
  } state_type;
endpackage

// *** verilog/check_if.sv ***
`timescale 1ns/100ps
interface check_if;
  logic [7:0] func;
  logic [15:0] word1;
  logic [15:0] word2;
  logic coil_sel;
  logic bcast;
  logic [7:0] exc;
  modbus_pkg::reply_type reply;
  logic needs_prim;
  logic [7:0] prim_code;
  logic [7:0] transfer_type_code;
  logic [15:0] prim_addr;
  logic [15:0] prim_count;
  logic [15:0] prim_data;
  modbus_pkg::coil_action_type coil_action;
  modport requester (output func, word1, word2, coil_sel, bcast,
    input exc, reply, needs_prim, prim_code, transfer_type_code, prim_addr, prim_count, prim_data, coil_action);
  modport checker_side (input func, word1, word2, coil_sel, bcast,
    output exc, reply, needs_prim, prim_code, transfer_type_code, prim_addr, prim_count, prim_data, coil_action);
endinterface

// *** verilog/request_checker.sv ***
`timescale 1ns/100ps
module request_checker (
  check_if.checker_side chk
);
  // decode, check and map one request; purely combinational so a reject never reaches downstream
  always_comb begin
    chk.exc = modbus_pkg::EXC_NONE;
    chk.reply = modbus_pkg::REPLY_ECHO;
    chk.needs_prim = 1'b1;
    chk.prim_code = modbus_pkg::PRIM_READ;
    chk.transfer_type_code = modbus_pkg::TT_VARIABLE;
    chk.prim_addr = chk.word1;
    chk.prim_count = chk.word2;
    chk.prim_data = chk.word2;
    chk.coil_action = modbus_pkg::COIL_OFF;
    case (chk.func)
      modbus_pkg::FN_RD_HOLD, modbus_pkg::FN_RD_INPUT: begin
        chk.reply = modbus_pkg::REPLY_DATA;
        chk.transfer_type_code = (chk.func == modbus_pkg::FN_RD_INPUT) ?
          modbus_pkg::TT_WORD_INPUT : modbus_pkg::TT_VARIABLE;
        if (chk.word2 > modbus_pkg::MAX_REGS || chk.word2 == modbus_pkg::RST_WORD) begin
          chk.exc = modbus_pkg::EXC_BAD_VALUE;
        end
      end
      modbus_pkg::FN_WR_COIL: begin
        chk.prim_code = modbus_pkg::PRIM_WRITE;
        chk.prim_count = 16'h0001;
        chk.transfer_type_code = chk.coil_sel ? modbus_pkg::TT_INT_COIL : modbus_pkg::TT_OUT_COIL;
        case (chk.word2)
          modbus_pkg::CODE_ON: chk.coil_action = modbus_pkg::COIL_ON;
          modbus_pkg::CODE_OFF: chk.coil_action = modbus_pkg::COIL_OFF;
          modbus_pkg::CODE_FORCE_ON: chk.coil_action = modbus_pkg::COIL_FORCE_ON;
          modbus_pkg::CODE_FORCE_OFF: chk.coil_action = modbus_pkg::COIL_FORCE_OFF;
          modbus_pkg::CODE_UNFORCE: chk.coil_action = modbus_pkg::COIL_UNFORCE;
          default: chk.exc = modbus_pkg::EXC_BAD_VALUE;
        endcase
      end
      modbus_pkg::FN_WR_REG: begin
        chk.prim_code = modbus_pkg::PRIM_WRITE;
        chk.prim_count = 16'h0001;
      end
      modbus_pkg::FN_RD_STATUS: begin
        chk.reply = modbus_pkg::REPLY_STATUS;
        chk.prim_addr = modbus_pkg::STATUS_START;
        chk.prim_count = modbus_pkg::STATUS_COUNT;
        chk.transfer_type_code = chk.coil_sel ? modbus_pkg::TT_INT_PACKED : modbus_pkg::TT_OUT_PACKED;
      end
      default: chk.exc = modbus_pkg::EXC_ILLEGAL_FN;
    endcase
    // reads cannot be answered to a broadcast, so they are dropped untouched
    if (chk.bcast && (chk.reply != modbus_pkg::REPLY_ECHO || chk.exc != modbus_pkg::EXC_NONE)) begin
      chk.reply = modbus_pkg::REPLY_NONE;
      chk.needs_prim = 1'b0;
    end
    if (chk.exc != modbus_pkg::EXC_NONE) begin
      chk.needs_prim = 1'b0;
      if (!chk.bcast) begin
        chk.reply = modbus_pkg::REPLY_EXC;
      end
    end
  end
endmodule // request_checker

// *** verilog/modbus_slave_command_translator.sv ***
`timescale 1ns/100ps
// Functional notes
// - function 04 reads sequential input registers
// - over 125 registers rejects with code 03
// - byte count twice registers, ascending data
// - decode five coil codes for function 05
// - other coil codes answer 03, no change
// - broadcast coil write goes to all secondaries
// - coil write echoed, broadcast gets no reply
// - switch picks coil area, type 4/5
// - function 06 writes one variable-memory register
// - broadcast register write goes to all secondaries
// - register write echoed, broadcast gets no reply
// - register write uses primitive 30 type 01
// - input read uses primitive 20 type 09
// - function 07 packs first 8 coils
// - status read primitive 20, locations 1-8
// - controller memory reject answers code 02
// - holding read uses primitive 20 type 01
module modbus_slave_command_translator (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // configuration switches (asynchronous pins)
  input wire logic [7:0] own_addr_pin,
  input wire logic coil_switch_pin,
  // decoded request from the host
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_slave,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_word1,
  input wire logic [15:0] req_word2,
  // primitive to the attached controllers
  output logic prim_valid,
  input wire logic prim_ready,
  output logic [7:0] prim_code,
  output logic [7:0] transfer_type_code,
  output logic prim_broadcast,
  output logic [15:0] prim_addr,
  output logic [15:0] prim_count,
  output logic [15:0] prim_data,
  output modbus_pkg::coil_action_type prim_coil_action,
  // controller status and read data
  input wire logic stat_valid,
  input wire logic stat_reject,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire logic [15:0] rd_word,
  // reply byte stream to the host
  output logic rsp_valid,
  input wire logic rsp_ready,
  output logic [7:0] rsp_byte,
  output logic rsp_last
);
  check_if chk ();
  request_checker u_checker (.chk(chk));

  logic [7:0] addr_meta_reg, own_addr_reg;
  logic sel_meta_reg, coil_sel_reg;
  modbus_pkg::state_type state_reg, state_next;
  modbus_pkg::reply_type kind_reg, kind_next;
  logic [7:0] exc_reg, exc_next, func_reg;
  logic [15:0] w1_reg, w2_reg, word_reg, left_reg;
  logic [2:0] idx_reg, idx_next;
  logic bcast_reg, take, match, hdr_end;

  // header byte i of the reply; byte 0 is always our own address
  function automatic logic [7:0] hdr_byte(input logic [2:0] i, input modbus_pkg::reply_type k,
      input logic [7:0] own, input logic [7:0] fn, input logic [7:0] ex, input logic [15:0] a,
      input logic [15:0] b);
    case (i)
      3'h0: hdr_byte = own;
      3'h1: hdr_byte = (k == modbus_pkg::REPLY_EXC) ? (fn | modbus_pkg::EXC_FLAG) : fn;
      3'h2: hdr_byte = (k == modbus_pkg::REPLY_EXC) ? ex :
                       (k == modbus_pkg::REPLY_DATA) ? {b[6:0], 1'b0} : a[15:8];
      3'h3: hdr_byte = a[7:0];
      3'h4: hdr_byte = b[15:8];
      default: hdr_byte = b[7:0];
    endcase
  endfunction

  function automatic logic [2:0] hdr_len(input modbus_pkg::reply_type k);
    case (k)
      modbus_pkg::REPLY_EXC: hdr_len = modbus_pkg::LEN_EXC;
      modbus_pkg::REPLY_DATA: hdr_len = modbus_pkg::LEN_DATA;
      modbus_pkg::REPLY_STATUS: hdr_len = modbus_pkg::LEN_STATUS;
      default: hdr_len = modbus_pkg::LEN_ECHO;
    endcase
  endfunction

  // switches are set by hand, so two flops per bit before use
  always_ff @(posedge clk) begin
    addr_meta_reg <= own_addr_pin;
    own_addr_reg <= addr_meta_reg;
    sel_meta_reg <= coil_switch_pin;
    coil_sel_reg <= sel_meta_reg;
  end

  assign chk.func = req_func;
  assign chk.word1 = req_word1;
  assign chk.word2 = req_word2;
  assign chk.coil_sel = coil_sel_reg;
  assign chk.bcast = (req_slave == modbus_pkg::BCAST_ADDR);
  assign match = chk.bcast || req_slave == own_addr_reg;
  assign take = state_reg == modbus_pkg::ST_IDLE && req_valid;
  assign hdr_end = idx_reg == hdr_len(kind_reg) - 3'h1;

  assign req_ready = state_reg == modbus_pkg::ST_IDLE;
  assign rd_ready = state_reg == modbus_pkg::ST_LOAD;
  assign rsp_valid = state_reg == modbus_pkg::ST_SEND || state_reg == modbus_pkg::ST_DATA_HI ||
                     state_reg == modbus_pkg::ST_DATA_LO;
  assign rsp_last = (state_reg == modbus_pkg::ST_SEND && hdr_end &&
                     (kind_reg == modbus_pkg::REPLY_EXC || kind_reg == modbus_pkg::REPLY_ECHO)) ||
                    (state_reg == modbus_pkg::ST_DATA_LO && left_reg == 16'h0001);

  // sequencing of one command: check, issue, wait, reply
  always_comb begin
    state_next = state_reg;
    kind_next = kind_reg;
    exc_next = exc_reg;
    idx_next = idx_reg;
    case (state_reg)
      modbus_pkg::ST_IDLE: if (req_valid && match) begin
        kind_next = chk.reply;
        exc_next = chk.exc;
        idx_next = 3'h0;
        if (chk.needs_prim) begin
          state_next = modbus_pkg::ST_ISSUE;
        end else if (chk.reply != modbus_pkg::REPLY_NONE) begin
          state_next = modbus_pkg::ST_SEND;
        end
      end
      modbus_pkg::ST_ISSUE: if (prim_ready) state_next = modbus_pkg::ST_WAIT;
      modbus_pkg::ST_WAIT: if (stat_valid) begin
        if (stat_reject) begin
          kind_next = modbus_pkg::REPLY_EXC;
          exc_next = modbus_pkg::EXC_MEMORY;
        end
        // broadcasts never answer, not even a reject
        state_next = bcast_reg ? modbus_pkg::ST_IDLE : modbus_pkg::ST_SEND;
      end
      modbus_pkg::ST_SEND: if (rsp_ready) begin
        if (!hdr_end) idx_next = idx_reg + 3'h1;
        else if (kind_reg == modbus_pkg::REPLY_DATA || kind_reg == modbus_pkg::REPLY_STATUS)
          state_next = modbus_pkg::ST_LOAD;
        else state_next = modbus_pkg::ST_IDLE;
      end
      modbus_pkg::ST_LOAD: if (rd_valid)
        state_next = (kind_reg == modbus_pkg::REPLY_STATUS) ? modbus_pkg::ST_DATA_LO : modbus_pkg::ST_DATA_HI;
      modbus_pkg::ST_DATA_HI: if (rsp_ready) state_next = modbus_pkg::ST_DATA_LO;
      modbus_pkg::ST_DATA_LO: if (rsp_ready)
        state_next = (left_reg == 16'h0001) ? modbus_pkg::ST_IDLE : modbus_pkg::ST_LOAD;
      default: state_next = modbus_pkg::ST_IDLE;
    endcase
  end

  // control state
  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= modbus_pkg::ST_IDLE;
      kind_reg <= modbus_pkg::REPLY_NONE;
      exc_reg <= modbus_pkg::EXC_NONE;
      idx_reg <= 3'h0;
    end else begin
      state_reg <= state_next;
      kind_reg <= kind_next;
      exc_reg <= exc_next;
      idx_reg <= idx_next;
    end
  end

  // request fields kept for the echo and header
  always_ff @(posedge clk) begin
    if (srst) begin
      func_reg <= modbus_pkg::RST_BYTE;
      w1_reg <= modbus_pkg::RST_WORD;
      w2_reg <= modbus_pkg::RST_WORD;
      bcast_reg <= 1'b0;
    end else if (take) begin
      func_reg <= req_func;
      w1_reg <= req_word1;
      w2_reg <= req_word2;
      bcast_reg <= chk.bcast;
    end
  end

  // primitive held stable until the controller side takes it
  always_ff @(posedge clk) begin
    if (srst) begin
      prim_valid <= 1'b0;
      prim_code <= modbus_pkg::RST_BYTE;
      transfer_type_code <= modbus_pkg::RST_BYTE;
      prim_broadcast <= 1'b0;
      prim_addr <= modbus_pkg::RST_WORD;
      prim_count <= modbus_pkg::RST_WORD;
      prim_data <= modbus_pkg::RST_WORD;
      prim_coil_action <= modbus_pkg::COIL_OFF;
    end else if (take && match && chk.needs_prim) begin
      prim_valid <= 1'b1;
      prim_code <= chk.prim_code;
      transfer_type_code <= chk.transfer_type_code;
      prim_broadcast <= chk.bcast;
      prim_addr <= chk.prim_addr;
      prim_count <= chk.prim_count;
      prim_data <= chk.prim_data;
      prim_coil_action <= chk.coil_action;
    end else if (state_reg == modbus_pkg::ST_ISSUE && prim_ready) begin
      prim_valid <= 1'b0;
    end
  end

  // returned words; count of words still owed to the host
  always_ff @(posedge clk) begin
    if (srst) begin
      word_reg <= modbus_pkg::RST_WORD;
      left_reg <= modbus_pkg::RST_WORD;
    end else if (take) begin
      left_reg <= (chk.reply == modbus_pkg::REPLY_STATUS) ? 16'h0001 : req_word2;
    end else if (state_reg == modbus_pkg::ST_LOAD && rd_valid) begin
      word_reg <= rd_word;
    end else if (state_reg == modbus_pkg::ST_DATA_LO && rsp_ready) begin
      left_reg <= left_reg - 16'h0001;
    end
  end

  // reply byte registered one step ahead of its state
  always_ff @(posedge clk) begin
    if (srst) begin
      rsp_byte <= modbus_pkg::RST_BYTE;
    end else begin
      case (state_next)
        modbus_pkg::ST_SEND: rsp_byte <= hdr_byte(idx_next, kind_reg, own_addr_reg, func_reg, exc_next, w1_reg, w2_reg);
        modbus_pkg::ST_DATA_HI: rsp_byte <= (state_reg == modbus_pkg::ST_LOAD) ? rd_word[15:8] : word_reg[15:8];
        modbus_pkg::ST_DATA_LO: rsp_byte <= (state_reg == modbus_pkg::ST_LOAD) ? rd_word[7:0] : word_reg[7:0];
        default: rsp_byte <= modbus_pkg::RST_BYTE;
      endcase
    end
  end

  property p_qty_reject;
    @(posedge clk) disable iff (srst)
    take && match && req_func == modbus_pkg::FN_RD_INPUT && req_word2 > modbus_pkg::MAX_REGS && !chk.bcast
    |=> state_reg == modbus_pkg::ST_SEND && exc_reg == modbus_pkg::EXC_BAD_VALUE && !prim_valid;
  endproperty
  a_qty_reject: assert property (p_qty_reject) else $error("oversize read not rejected");

  property p_bad_coil;
    @(posedge clk) disable iff (srst)
    take && match && req_func == modbus_pkg::FN_WR_COIL && chk.exc != modbus_pkg::EXC_NONE |=> !prim_valid;
  endproperty
  a_bad_coil: assert property (p_bad_coil) else $error("illegal coil code reached controller");

  property p_first_byte;
    @(posedge clk) disable iff (srst)
    state_reg == modbus_pkg::ST_SEND && idx_reg == 3'h0 |-> rsp_byte == own_addr_reg;
  endproperty
  a_first_byte: assert property (p_first_byte) else $error("reply not led by own address");

  property p_byte_count;
    @(posedge clk) disable iff (srst)
    state_reg == modbus_pkg::ST_SEND && kind_reg == modbus_pkg::REPLY_DATA && idx_reg == 3'h2
    |-> rsp_byte == {w2_reg[6:0], 1'b0};
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte count not twice quantity");

  property p_input_prim;
    @(posedge clk) disable iff (srst)
    take && match && req_func == modbus_pkg::FN_RD_INPUT && chk.needs_prim
    |=> prim_valid && prim_code == modbus_pkg::PRIM_READ && transfer_type_code == modbus_pkg::TT_WORD_INPUT;
  endproperty
  a_input_prim: assert property (p_input_prim) else $error("input read mapped wrongly");

  property p_reg_write_prim;
    @(posedge clk) disable iff (srst)
    prim_valid && func_reg == modbus_pkg::FN_WR_REG
    |-> prim_code == modbus_pkg::PRIM_WRITE && transfer_type_code == modbus_pkg::TT_VARIABLE;
  endproperty
  a_reg_write_prim: assert property (p_reg_write_prim) else $error("register write mapped wrongly");

  property p_bcast_silent;
    @(posedge clk) disable iff (srst)
    state_reg == modbus_pkg::ST_WAIT && stat_valid && bcast_reg |=> state_reg == modbus_pkg::ST_IDLE ##1 !rsp_valid;
  endproperty
  a_bcast_silent: assert property (p_bcast_silent) else $error("broadcast produced a reply");

  property p_mem_reject;
    @(posedge clk) disable iff (srst)
    state_reg == modbus_pkg::ST_WAIT && stat_valid && stat_reject && !bcast_reg
    |=> state_reg == modbus_pkg::ST_SEND && kind_reg == modbus_pkg::REPLY_EXC && exc_reg == modbus_pkg::EXC_MEMORY;
  endproperty
  a_mem_reject: assert property (p_mem_reject) else $error("controller reject not code 02");

  property p_issue_after_check;
    @(posedge clk) disable iff (srst)
    $rose(prim_valid) |-> $past(state_reg) == modbus_pkg::ST_IDLE && state_reg == modbus_pkg::ST_ISSUE;
  endproperty
  a_issue_after_check: assert property (p_issue_after_check) else $error("primitive outside issue");
endmodule // modbus_slave_command_translator

// *** verification/controller_model.sv ***
`timescale 1ns/100ps
// attached controller: takes primitives, reports completion, serves read words
module controller_model (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // scenario controls
  input wire logic slow,
  input wire logic reject,
  // primitive from the translator
  input wire logic prim_valid,
  output logic prim_ready,
  input wire logic [7:0] prim_code,
  input wire logic [7:0] transfer_type_code,
  input wire logic [15:0] prim_addr,
  input wire logic [15:0] prim_count,
  // completion and read words
  output logic stat_valid,
  output logic stat_reject,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [15:0] rd_word
);
  logic [1:0] phase_reg;
  logic [3:0] wait_reg;
  logic [15:0] addr_reg;
  logic [15:0] left_reg;
  // pause, accept, pause, report, then hand out words; slow mode stretches both pauses
  always @(posedge clk) begin
    stat_valid <= 1'b0;
    stat_reject <= 1'b0;
    if (srst) begin
      prim_ready <= 1'b0;
      phase_reg <= 2'h0;
      wait_reg <= 4'h0;
      left_reg <= 16'h0000;
      rd_valid <= 1'b0;
      rd_word <= 16'hffff;
    end else if (prim_valid && prim_ready) begin
      prim_ready <= 1'b0;
      phase_reg <= 2'h1;
      wait_reg <= 4'h0;
      addr_reg <= prim_addr;
      // packed coil reads come back as one word; anything more would be left hanging and block the next primitive
      left_reg <= (prim_code != 8'h20 || reject) ? 16'h0000 :
        (transfer_type_code == 8'h07 || transfer_type_code == 8'h08) ? 16'h0001 : prim_count;
    end else if (phase_reg == 2'h2) begin
      if (rd_valid && rd_ready) begin
        // a word taken: next one, or release the line showing a changed value
        left_reg <= left_reg - 16'h0001;
        addr_reg <= addr_reg + 16'h0001;
        rd_valid <= (left_reg != 16'h0001);
        rd_word <= (left_reg != 16'h0001) ? ((addr_reg + 16'h0001) ^ 16'h5a3a) : ~rd_word;
        if (left_reg == 16'h0001) begin
          phase_reg <= 2'h0;
        end
      end else begin
        // status word at location 1 carries 3b in its low byte
        rd_valid <= 1'b1;
        rd_word <= addr_reg ^ 16'h5a3a;
      end
    end else if (wait_reg != (slow ? 4'h9 : 4'h1)) begin
      wait_reg <= (phase_reg == 2'h0 && !prim_valid) ? 4'h0 : wait_reg + 4'h1;
    end else if (phase_reg == 2'h1) begin
      stat_valid <= 1'b1;
      stat_reject <= reject;
      phase_reg <= (left_reg != 16'h0000) ? 2'h2 : 2'h0;
      wait_reg <= 4'h0;
    end else begin
      prim_ready <= prim_valid;
    end
  end
endmodule // controller_model

// *** verification/testbench.sv ***
`timescale 1ns/100ps
module testbench;
  localparam logic [7:0] own_addr = 8'h07;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic sw = 1'b0;
  logic slow = 1'b0;
  logic reject = 1'b0;
  logic stall = 1'b0;
  logic req_valid = 1'b0;
  logic rsp_ready = 1'b1;
  logic [7:0] req_slave = 8'h00;
  logic [7:0] req_func = 8'h00;
  logic [15:0] req_word1 = 16'h0000;
  logic [15:0] req_word2 = 16'h0000;
  logic req_ready, prim_valid, prim_ready, prim_broadcast, stat_valid, stat_reject;
  logic rd_valid, rd_ready, rsp_valid, rsp_last;
  logic [7:0] prim_code, transfer_type_code, rsp_byte;
  logic [15:0] prim_addr, prim_count, prim_data, rd_word;
  modbus_pkg::coil_action_type prim_coil_action;
  int error_cnt = 0;
  int cmp_count = 0;
  int prim_n = 0;
  int last_at = -1;
  logic [7:0] rsp_q[$];
  logic [7:0] exp_q[$];
  logic [15:0] seen[7];
  always #50 clk = ~clk;
  modbus_slave_command_translator modbus_slave_command_translator_inst (.clk, .srst, .own_addr_pin(own_addr),
    .coil_switch_pin(sw), .req_valid, .req_ready, .req_slave, .req_func, .req_word1, .req_word2, .prim_valid,
    .prim_ready, .prim_code, .transfer_type_code, .prim_broadcast, .prim_addr, .prim_count, .prim_data,
    .prim_coil_action, .stat_valid, .stat_reject, .rd_valid, .rd_ready, .rd_word, .rsp_valid, .rsp_ready,
    .rsp_byte, .rsp_last);
  controller_model controller_model_inst (.clk, .srst, .slow, .reject, .prim_valid, .prim_ready, .prim_code,
    .transfer_type_code, .prim_addr, .prim_count, .stat_valid, .stat_reject, .rd_valid, .rd_ready, .rd_word);
  // host side may stall the reply stream every other cycle
  always @(negedge clk) rsp_ready <= stall ? ~rsp_ready : 1'b1;
  // record the last primitive handed over and every reply byte accepted
  always @(posedge clk) begin
    if (prim_valid && prim_ready) begin
      prim_n <= prim_n + 1;
      seen <= '{16'(prim_code), 16'(transfer_type_code), 16'(prim_broadcast), prim_addr, prim_count, prim_data,
        16'(prim_coil_action)};
    end
    if (rsp_valid && rsp_ready && rsp_last) last_at <= rsp_q.size();
    if (rsp_valid && rsp_ready) rsp_q.push_back(rsp_byte);
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one request, held a single cycle while idle, then wait for idle again
  task automatic cmd(input logic [7:0] sl, input logic [7:0] fn, input logic [15:0] w1, input logic [15:0] w2);
    rsp_q.delete();
    last_at = -1;
    req_slave = sl;
    req_func = fn;
    req_word1 = w1;
    req_word2 = w2;
    req_valid = 1'b1;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < 3000 && req_ready !== 1'b1; i++) @(negedge clk);
    chk("idle", 16'h0001, 16'(req_ready));
  endtask
  task automatic cmp_reply();
    chk("reply length", 16'(exp_q.size()), 16'(rsp_q.size()));
    chk("last byte marker", 16'(exp_q.size() - 1), 16'(last_at));
    foreach (exp_q[i]) chk("reply byte", {8'h00, exp_q[i]}, (i < rsp_q.size()) ? {8'h00, rsp_q[i]} : 16'hxxxx);
  endtask
  task automatic cmp_prim(input int n0, input logic [15:0] code, tt, bc, addr);
    chk("primitive number", 16'(n0 + 1), 16'(prim_n));
    chk("primitive code", code, seen[0]);
    chk("transfer type", tt, seen[1]);
    chk("broadcast flag", bc, seen[2]);
    chk("primitive address", addr, seen[3]);
  endtask
  // refused request: three-byte exception and no downstream access
  task automatic refused(input logic [7:0] fn, input logic [15:0] w1, w2, input logic [7:0] code);
    int n0;
    n0 = prim_n;
    cmd(own_addr, fn, w1, w2);
    chk("primitive number", 16'(n0), 16'(prim_n));
    exp_q = '{own_addr, fn | 8'h80, code};
    cmp_reply();
  endtask
  // no reply may follow; np primitives expected
  task automatic silent(input logic [7:0] sl, fn, input logic [15:0] w1, w2, input int np);
    int n0;
    n0 = prim_n;
    cmd(sl, fn, w1, w2);
    repeat (20) @(negedge clk);
    chk("primitive number", 16'(n0 + np), 16'(prim_n));
    chk("reply length", 16'h0000, 16'(rsp_q.size()));
  endtask
  // words follow the model pattern: address xor 5a3a, high byte first
  task automatic read_regs(input logic [7:0] fn, tt, input logic [15:0] a, q);
    int n0;
    n0 = prim_n;
    cmd(own_addr, fn, a, q);
    cmp_prim(n0, 16'h0020, 16'(tt), 16'h0000, a);
    chk("primitive count field", q, seen[4]);
    exp_q = '{own_addr, fn, 8'(2 * q)};
    for (int i = 0; i < int'(q); i++) begin
      exp_q.push_back(8'(((a + 16'(i)) ^ 16'h5a3a) >> 8));
      exp_q.push_back(8'((a + 16'(i)) ^ 16'h5a3a));
    end
    cmp_reply();
  endtask
  task automatic t_reads();
    read_regs(8'h03, 8'h01, 16'h0064, 16'h0003);
    slow = 1'b1;
    stall = 1'b1;
    read_regs(8'h04, 8'h09, 16'h0008, 16'h007d);
    slow = 1'b0;
    stall = 1'b0;
    refused(8'h04, 16'h0008, 16'h007e, 8'h03);
    refused(8'h03, 16'h0064, 16'h007e, 8'h03);
    refused(8'h04, 16'h0008, 16'h0000, 8'h03);
    refused(8'h01, 16'h0008, 16'h0001, 8'h01);
    silent(8'h22, 8'h04, 16'h0008, 16'h0001, 0);
  endtask
  task automatic t_coils();
    logic [15:0] codes[5] = '{16'hff00, 16'h0000, 16'h1100, 16'h2200, 16'h3300};
    logic [15:0] acts[5] = '{16'h0001, 16'h0000, 16'h0002, 16'h0003, 16'h0004};
    int n0;
    for (int s = 0; s < 2; s++) begin
      sw = s[0];
      repeat (4) @(negedge clk);
      for (int k = 0; k < 5; k++) begin
        n0 = prim_n;
        cmd(own_addr, 8'h05, 16'h0064, codes[k]);
        cmp_prim(n0, 16'h0030, s ? 16'h0005 : 16'h0004, 16'h0000, 16'h0064);
        chk("coil action", acts[k], seen[6]);
        exp_q = '{own_addr, 8'h05, 8'h00, 8'h64, codes[k][15:8], codes[k][7:0]};
        cmp_reply();
      end
    end
    refused(8'h05, 16'h0064, 16'hff01, 8'h03);
    silent(8'h00, 8'h05, 16'h0064, 16'h2200, 1);
    chk("broadcast flag", 16'h0001, seen[2]);
    chk("coil action", 16'h0003, seen[6]);
  endtask
  task automatic t_regs();
    int n0;
    n0 = prim_n;
    cmd(own_addr, 8'h06, 16'h0064, 16'h0220);
    cmp_prim(n0, 16'h0030, 16'h0001, 16'h0000, 16'h0064);
    chk("primitive data", 16'h0220, seen[5]);
    exp_q = '{own_addr, 8'h06, 8'h00, 8'h64, 8'h02, 8'h20};
    cmp_reply();
    silent(8'h00, 8'h06, 16'h0065, 16'h0321, 1);
    chk("broadcast flag", 16'h0001, seen[2]);
    chk("primitive data", 16'h0321, seen[5]);
  endtask
  // both coil areas; the model's location 1 holds 3b in its low byte
  task automatic t_status();
    int n0;
    for (int s = 0; s < 2; s++) begin
      sw = s[0];
      repeat (4) @(negedge clk);
      n0 = prim_n;
      cmd(own_addr, 8'h07, 16'h0000, 16'h0000);
      cmp_prim(n0, 16'h0020, s ? 16'h0008 : 16'h0007, 16'h0000, 16'h0001);
      chk("primitive count field", 16'h0008, seen[4]);
      exp_q = '{own_addr, 8'h07, 8'h3b};
      cmp_reply();
    end
  endtask
  task automatic t_mem_reject();
    int n0;
    reject = 1'b1;
    n0 = prim_n;
    cmd(own_addr, 8'h03, 16'h0100, 16'h0002);
    cmp_prim(n0, 16'h0020, 16'h0001, 16'h0000, 16'h0100);
    exp_q = '{own_addr, 8'h83, 8'h02};
    cmp_reply();
    silent(8'h00, 8'h06, 16'h0100, 16'h0001, 1);
    reject = 1'b0;
  endtask
  task automatic test_done();
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // watchdog well beyond the thousand or so cycles the scenarios need
  initial begin
    repeat (30000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  initial begin
    repeat (12) @(negedge clk);
    srst = 1'b0;
    chk("reset ready", 16'h0001, 16'(req_ready));
    chk("reset reply valid", 16'h0000, 16'(rsp_valid));
    t_reads();
    t_coils();
    t_regs();
    t_status();
    t_mem_reject();
    test_done();
  end
endmodule // testbench
